/* File: hdl/msr_pkg.sv */
/*
 * Constants and state type of the read command unit.
 * Assumes one device clock.
 */
package msr_pkg;

    // command opcodes
    localparam logic [7:0] OP_READ_LOG      = 8'h2F;
    localparam logic [7:0] OP_READ_LOG_DMA  = 8'h47;
    localparam logic [7:0] OP_READ_MULTIPLE = 8'hC4;

    // served log page
    localparam logic [7:0] LOG_PAGE_PHY     = 8'h11;
    localparam logic [7:0] LOG_SECTORS      = 8'h01;

    // sector and log layout
    localparam int         WORDS_PER_SECTOR = 256;
    localparam int         LOG_BYTES        = 512;
    localparam int         LOG_SUM_BYTES    = 511;
    localparam logic [7:0] LAST_WORD        = 8'hFF;
    localparam logic [8:0] FULL_COUNT       = 9'h100;
    localparam int         CNT_FIRST_WORD   = 2;
    localparam int         NUM_CNT          = 11;
    localparam logic [2:0] CNT_SIZE_CODE    = 3'h1;
    localparam logic [NUM_CNT-1:0][11:0] CNT_IDS = {
        12'h00D, 12'h00B, 12'h00A, 12'h009, 12'h007, 12'h006,
        12'h005, 12'h004, 12'h003, 12'h002, 12'h001
    };

    // device field
    localparam int         DEV_ADDR_MODE    = 6;

    // status bits
    localparam int         ST_BSY           = 7;
    localparam int         ST_RDY           = 6;
    localparam int         ST_SEEK_DONE     = 4;
    localparam int         ST_DRQ           = 3;
    localparam int         ST_ERR           = 0;
    localparam logic [7:0] STATUS_RST       = 8'h50;

    // error bits
    localparam int         ER_UNCORR        = 6;
    localparam int         ER_IDNF          = 4;
    localparam int         ER_ABRT          = 2;
    localparam logic [7:0] ERROR_RST        = 8'h00;

    // CHS stepping geometry
    localparam logic [7:0] SECTORS_PER_TRACK = 8'h3F;
    localparam logic [4:0] HEAD_COUNT        = 5'h10;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_XFER,
        S_LOG,
        S_DONE
    } state_t;

endpackage : msr_pkg

/* File: hdl/word_skid_buffer.sv */
/*
 * Two-entry skid buffer; ready and valid registered.
 * Assumes one clock on both sides.
 */
`timescale 1ns/1ps
module word_skid_buffer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i,
    // state
    output logic                  empty_o
);

    logic             out_valid_d;
    logic [WIDTH-1:0] out_data_d;
    logic             skid_valid_q;
    logic             skid_valid_d;
    logic [WIDTH-1:0] skid_data_q;
    logic [WIDTH-1:0] skid_data_d;
    logic             push;
    logic             pop;

    always_comb begin
        push         = in_valid_i & in_ready_o;
        pop          = out_valid_o & out_ready_i;
        out_valid_d  = out_valid_o;
        out_data_d   = out_data_o;
        skid_valid_d = skid_valid_q;
        skid_data_d  = skid_data_q;
        if (!out_valid_o || pop) begin
            if (skid_valid_q) begin
                out_data_d   = skid_data_q;
                skid_valid_d = push;
                skid_data_d  = in_data_i;
            end else begin
                out_valid_d  = push;
                out_data_d   = in_data_i;
            end
        end else if (push) begin
            skid_valid_d = 1'b1;
            skid_data_d  = in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o  <= 1'b0;
            out_data_o   <= '0;
            skid_valid_q <= 1'b0;
            skid_data_q  <= '0;
            in_ready_o   <= 1'b1;
        end else begin
            out_valid_o  <= out_valid_d;
            out_data_o   <= out_data_d;
            skid_valid_q <= skid_valid_d;
            skid_data_q  <= skid_data_d;
            in_ready_o   <= !skid_valid_d;
        end
    end

    assign empty_o = !out_valid_o && !skid_valid_q;

endmodule : word_skid_buffer

/* File: hdl/log_checksum.sv */
/*
 * Byte sum of log words; gives the zeroing byte.
 * Assumes the caller clears it per page.
 */
`timescale 1ns/1ps
module log_checksum (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // control
    input  wire logic        clear_i,
    input  wire logic        add_i,
    input  wire logic [15:0] word_i,
    // result
    output logic       [7:0] check_o
);

    logic [7:0] sum_q;
    logic [7:0] sum_d;

    always_comb begin
        sum_d = sum_q;
        if (clear_i) begin
            sum_d = 8'h00;
        end else if (add_i) begin
            sum_d = sum_q + word_i[7:0] + word_i[15:8];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sum_q <= 8'h00;
        end else begin
            sum_q <= sum_d;
        end
    end

    // negated running sum
    assign check_o = ~sum_q + 8'h01;

endmodule : log_checksum

/* File: hdl/multi_sector_read_command_unit.sv */
/*
 * Multi-sector read and event log read command unit.
 * Assumes all inputs come from logic on clk_i.
 */
// What this block does
// - log page last byte is two's complement of the 511-byte sum
// - opcode 47h log read takes the PIO log read path but interrupts at completion instead of at the start
// - opcode C4h reads sectors from media then sends them to host
// - sector data leaves through the data port in 16-bit words
// - one interrupt per block of sectors, block size set beforehand
// - sector count gives sectors to move; zero means 256
// - block addressing: address from low, mid, high bytes and head nibble
// - CHS addressing: low byte sector, mid/high cylinder, nibble head
// - on completion sector count returns sectors not transferred
// - on completion address fields hold last sector transferred
// - event log read with feature bit 0 returns then clears counters
`timescale 1ns/1ps
module multi_sector_read_command_unit #(
    parameter logic [7:0] SPT   = msr_pkg::SECTORS_PER_TRACK,
    parameter logic [4:0] HEADS = msr_pkg::HEAD_COUNT
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // command taskfile
    input  wire logic                        cmd_valid_i,
    input  wire logic                  [7:0] opcode_i,
    input  wire logic                  [7:0] feature_i,
    input  wire logic                  [7:0] sector_count_i,
    input  wire logic                  [7:0] addr_low_i,
    input  wire logic                  [7:0] addr_mid_i,
    input  wire logic                  [7:0] addr_high_i,
    input  wire logic                  [7:0] device_i,
    input  wire logic                  [7:0] block_size_i,
    // media side
    output logic                             media_rd_o,
    output logic                      [27:0] media_addr_o,
    output logic                             media_block_mode_o,
    input  wire logic                        media_valid_i,
    input  wire logic                 [15:0] media_word_i,
    output logic                             media_ready_o,
    input  wire logic                        media_unc_i,
    input  wire logic                        media_nf_i,
    // event counters
    input  wire logic [msr_pkg::NUM_CNT-1:0] event_i,
    // host data port
    output logic                             data_valid_o,
    output logic                      [15:0] data_o,
    input  wire logic                        data_ready_i,
    // completion and taskfile results
    output logic                             intrq_o,
    output logic                             done_o,
    output logic                       [7:0] status_o,
    output logic                       [7:0] error_o,
    output logic                       [7:0] sector_count_o,
    output logic                       [7:0] addr_low_o,
    output logic                       [7:0] addr_mid_o,
    output logic                       [7:0] addr_high_o,
    output logic                       [3:0] head_o
);

    msr_pkg::state_t state_q, state_d;
    logic        block_mode_q, block_mode_d;
    logic [27:0] addr_d;
    logic [27:0] last_q, last_d;
    logic [8:0]  remain_q, remain_d;
    logic [7:0]  blk_q, blk_d;
    logic [7:0]  blk_size_q, blk_size_d;
    logic [7:0]  word_q, word_d;
    logic [7:0]  err_q, err_d;
    logic        dma_q, dma_d;
    logic        cnt_clr_req_q, cnt_clr_req_d;
    logic        media_rd_d;
    logic        irq_d;
    logic        done_d;
    logic [7:0]  status_d;
    logic [7:0]  res_count_d;
    logic [27:0] res_addr_q, res_addr_d;
    logic        cnt_clr;
    logic [15:0] cnt_q [msr_pkg::NUM_CNT];
    logic [15:0] log_word;
    logic        buf_in_valid;
    logic [15:0] buf_in_word;
    logic        buf_ready;
    logic        buf_empty;
    logic        chk_clear;
    logic        chk_add;
    logic [7:0]  chk;
    logic        is_log;

    // next sector; CHS wraps sector then head
    function automatic logic [27:0] next_addr(input logic [27:0] a, input logic blk_mode);
        logic [7:0]  s;
        logic [3:0]  h;
        logic [15:0] c;
        s = a[7:0];
        c = a[23:8];
        h = a[27:24];
        if (blk_mode) begin
            return a + 28'h000_0001;
        end
        if (s >= SPT) begin
            s = 8'h01;
            if ({1'b0, h} + 5'h01 >= HEADS) begin
                h = 4'h0;
                c = c + 16'h0001;
            end else begin
                h = h + 4'h1;
            end
        end else begin
            s = s + 8'h01;
        end
        return {h, c, s};
    endfunction : next_addr

    // saturating; an event while clearing counts
    for (genvar g = 0; g < msr_pkg::NUM_CNT; g++) begin : g_cnt
        logic [15:0] cnt_d;
        always_comb begin
            cnt_d = cnt_q[g];
            if (cnt_clr) begin
                cnt_d = {15'h0000, event_i[g]};
            end else if (event_i[g] && cnt_q[g] != 16'hFFFF) begin
                cnt_d = cnt_q[g] + 16'h0001;
            end
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_q[g] <= 16'h0000;
            end else begin
                cnt_q[g] <= cnt_d;
            end
        end
    end

    // page: zeros, id/value pairs, pad
    always_comb begin
        log_word = 16'h0000;
        for (int k = 0; k < msr_pkg::NUM_CNT; k++) begin
            if (word_q == 8'(msr_pkg::CNT_FIRST_WORD + 2 * k)) begin
                log_word = {1'b0, msr_pkg::CNT_SIZE_CODE, msr_pkg::CNT_IDS[k]};
            end
            if (word_q == 8'(msr_pkg::CNT_FIRST_WORD + 2 * k + 1)) begin
                log_word = cnt_q[k];
            end
        end
    end

    assign is_log = (opcode_i == msr_pkg::OP_READ_LOG) || (opcode_i == msr_pkg::OP_READ_LOG_DMA);

    always_comb begin
        state_d       = state_q;
        block_mode_d  = block_mode_q;
        addr_d        = media_addr_o;
        last_d        = last_q;
        remain_d      = remain_q;
        blk_d         = blk_q;
        blk_size_d    = blk_size_q;
        word_d        = word_q;
        err_d         = err_q;
        dma_d         = dma_q;
        cnt_clr_req_d = cnt_clr_req_q;
        media_rd_d    = 1'b0;
        irq_d         = 1'b0;
        done_d        = 1'b0;
        res_count_d   = sector_count_o;
        res_addr_d    = res_addr_q;
        buf_in_valid  = 1'b0;
        buf_in_word   = 16'h0000;
        chk_clear     = 1'b0;
        chk_add       = 1'b0;
        cnt_clr       = 1'b0;
        unique case (state_q)
            msr_pkg::S_IDLE: begin
                if (cmd_valid_i) begin
                    block_mode_d  = device_i[msr_pkg::DEV_ADDR_MODE];
                    addr_d        = {device_i[3:0], addr_high_i, addr_mid_i, addr_low_i};
                    last_d        = addr_d;
                    remain_d      = (sector_count_i == 8'h00) ? msr_pkg::FULL_COUNT
                                                              : {1'b0, sector_count_i};
                    blk_d         = 8'h00;
                    blk_size_d    = block_size_i;
                    word_d        = 8'h00;
                    err_d         = msr_pkg::ERROR_RST;
                    // both log opcodes share the path
                    dma_d         = (opcode_i == msr_pkg::OP_READ_LOG_DMA);
                    cnt_clr_req_d = feature_i[0];
                    chk_clear     = 1'b1;
                    if (is_log && addr_low_i == msr_pkg::LOG_PAGE_PHY
                            && sector_count_i == msr_pkg::LOG_SECTORS) begin
                        state_d = msr_pkg::S_LOG;
                        irq_d   = !dma_d;
                    end else if (opcode_i == msr_pkg::OP_READ_MULTIPLE && block_size_i != 8'h00) begin
                        state_d = msr_pkg::S_FETCH;
                    end else begin
                        err_d[msr_pkg::ER_ABRT] = 1'b1;
                        state_d                 = msr_pkg::S_DONE;
                    end
                end
            end
            msr_pkg::S_FETCH: begin
                media_rd_d = 1'b1;
                // interrupt only at the start of each block
                irq_d      = (blk_q == 8'h00);
                word_d     = 8'h00;
                state_d    = msr_pkg::S_XFER;
            end
            msr_pkg::S_XFER: begin
                // media words pass as 16-bit words
                buf_in_valid = media_valid_i;
                buf_in_word  = media_word_i;
                if (media_unc_i || media_nf_i) begin
                    err_d[msr_pkg::ER_UNCORR] = media_unc_i;
                    err_d[msr_pkg::ER_IDNF] = media_nf_i;
                    state_d                 = msr_pkg::S_DONE;
                end else if (media_valid_i && buf_ready) begin
                    word_d = word_q + 8'h01;
                    if (word_q == msr_pkg::LAST_WORD) begin
                        last_d   = media_addr_o;
                        addr_d   = next_addr(media_addr_o, block_mode_q);
                        remain_d = remain_q - 9'h001;
                        blk_d    = (blk_q + 8'h01 == blk_size_q) ? 8'h00 : blk_q + 8'h01;
                        state_d  = (remain_q == 9'h001) ? msr_pkg::S_DONE : msr_pkg::S_FETCH;
                    end
                end
            end
            msr_pkg::S_LOG: begin
                buf_in_valid = 1'b1;
                buf_in_word  = (word_q == msr_pkg::LAST_WORD) ? {chk, 8'h00} : log_word;
                if (buf_ready) begin
                    chk_add = (word_q != msr_pkg::LAST_WORD);
                    word_d  = word_q + 8'h01;
                    if (word_q == msr_pkg::LAST_WORD) begin
                        remain_d = 9'h000;
                        // counters cleared as the last page word enters the buffer
                        cnt_clr  = cnt_clr_req_q;
                        state_d  = msr_pkg::S_DONE;
                    end
                end
            end
            msr_pkg::S_DONE: begin
                // wait for host to drain
                if (buf_empty) begin
                    state_d     = msr_pkg::S_IDLE;
                    done_d      = 1'b1;
                    irq_d       = dma_q || (err_q != 8'h00);
                    res_count_d = remain_q[7:0];
                    res_addr_d  = last_q;
                end
            end
        endcase
        // error flag with busy clear once idle
        status_d                 = msr_pkg::STATUS_RST;
        status_d[msr_pkg::ST_BSY] = (state_d != msr_pkg::S_IDLE) && !data_valid_o;
        status_d[msr_pkg::ST_DRQ] = data_valid_o;
        status_d[msr_pkg::ST_ERR] = (err_d != 8'h00);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q        <= msr_pkg::S_IDLE;
            block_mode_q   <= 1'b0;
            media_addr_o   <= 28'h000_0000;
            last_q         <= 28'h000_0000;
            remain_q       <= 9'h000;
            blk_q          <= 8'h00;
            blk_size_q     <= 8'h00;
            word_q         <= 8'h00;
            err_q          <= msr_pkg::ERROR_RST;
            dma_q          <= 1'b0;
            cnt_clr_req_q  <= 1'b0;
            media_rd_o     <= 1'b0;
            intrq_o        <= 1'b0;
            done_o         <= 1'b0;
            status_o       <= msr_pkg::STATUS_RST;
            sector_count_o <= 8'h00;
            res_addr_q     <= 28'h000_0000;
        end else begin
            state_q        <= state_d;
            block_mode_q   <= block_mode_d;
            media_addr_o   <= addr_d;
            last_q         <= last_d;
            remain_q       <= remain_d;
            blk_q          <= blk_d;
            blk_size_q     <= blk_size_d;
            word_q         <= word_d;
            err_q          <= err_d;
            dma_q          <= dma_d;
            cnt_clr_req_q  <= cnt_clr_req_d;
            media_rd_o     <= media_rd_d;
            intrq_o        <= irq_d;
            done_o         <= done_d;
            status_o       <= status_d;
            sector_count_o <= res_count_d;
            res_addr_q     <= res_addr_d;
        end
    end

    assign media_block_mode_o = block_mode_q;
    assign error_o            = err_q;
    assign addr_low_o         = res_addr_q[7:0];
    assign addr_mid_o         = res_addr_q[15:8];
    assign addr_high_o        = res_addr_q[23:16];
    assign head_o             = res_addr_q[27:24];
    // registered buffer ready
    assign media_ready_o      = buf_ready;

    word_skid_buffer #(
        .WIDTH       (16)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (buf_in_valid),
        .in_data_i   (buf_in_word),
        .in_ready_o  (buf_ready),
        .out_valid_o (data_valid_o),
        .out_data_o  (data_o),
        .out_ready_i (data_ready_i),
        .empty_o     (buf_empty)
    );

    log_checksum u_chk (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clear_i (chk_clear),
        .add_i   (chk_add),
        .word_i  (buf_in_word),
        .check_o (chk)
    );

endmodule : multi_sector_read_command_unit

/* File: bench/msr_properties.sv */
/*
 * port checker for the read command unit.
 * assumes its clock and async reset.
 */
`timescale 1ns/1ps
module msr_properties (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        cmd_valid_i,
    input wire logic  [7:0] opcode_i,
    input wire logic  [7:0] device_i,
    input wire logic  [7:0] block_size_i,
    input wire logic        media_rd_o,
    input wire logic        media_block_mode_o,
    input wire logic        data_valid_o,
    input wire logic [15:0] data_o,
    input wire logic        data_ready_i,
    input wire logic        intrq_o,
    input wire logic        done_o,
    input wire logic  [7:0] status_o,
    input wire logic  [7:0] error_o,
    input wire logic  [7:0] sector_count_o
);
    logic       idle_q;
    logic       mode_q;
    logic [7:0] op_q;
    logic [7:0] blk_q;
    logic       bad_op;
    assign bad_op = opcode_i != 8'h2F && opcode_i != 8'h47 && opcode_i != 8'hC4;
    // free the cycle after done
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_q <= 1'b1;
            mode_q <= 1'b0;
            op_q   <= 8'h00;
            blk_q  <= 8'h00;
        end else if (idle_q && cmd_valid_i) begin
            idle_q <= 1'b0;
            mode_q <= device_i[msr_pkg::DEV_ADDR_MODE];
            op_q   <= opcode_i;
            blk_q  <= block_size_i;
        end else if (done_o) begin
            idle_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_abort_bad_op: assert property (idle_q && cmd_valid_i && bad_op |-> ##2
        done_o && error_o[msr_pkg::ER_ABRT] && status_o[msr_pkg::ST_ERR])
        else $error("no abort");
    a_err_flag_match: assert property (done_o |->
        status_o[msr_pkg::ST_ERR] == (|error_o) && !status_o[msr_pkg::ST_BSY])
        else $error("bad error flag");
    a_ok_none_left: assert property (done_o && op_q == 8'hC4 && !status_o[0] |->
        sector_count_o == 8'h00) else $error("sectors left");
    a_data_hold: assert property (data_valid_o && !data_ready_i |=>
        data_valid_o && $stable(data_o)) else $error("word lost");
    a_fetch_pulse: assert property (media_rd_o |=> !media_rd_o)
        else $error("long request");
    a_idle_quiet: assert property (idle_q |-> !media_rd_o && !data_valid_o)
        else $error("busy in idle");
    a_mode_follows: assert property (media_rd_o |-> media_block_mode_o == mode_q)
        else $error("wrong mode");
    a_dma_irq_done: assert property (done_o && op_q == 8'h47 |-> intrq_o)
        else $error("no dma interrupt");
    a_irq_each_blk: assert property (media_rd_o && blk_q == 8'h01 |-> intrq_o)
        else $error("no block interrupt");
endmodule : msr_properties

bind multi_sector_read_command_unit msr_properties u_props (.*);

/* File: bench/media_model.sv */
/*
 * media model: 256 words a sector, {addr byte, index}.
 * assumes one request at a time; may fail a sector.
 */
`timescale 1ns/1ps
module media_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        media_rd_i,
    input  wire logic [27:0] media_addr_i,
    input  wire logic        media_ready_i,
    input  wire logic [27:0] fail_addr_i,
    input  wire logic        fail_nf_i,
    output logic             media_valid_o,
    output logic      [15:0] media_word_o,
    output logic             media_unc_o,
    output logic             media_nf_o
);
    logic [27:0] addr_q;
    logic  [8:0] left_q;
    logic  [7:0] idx_q;
    logic        hit;
    assign hit = media_valid_o && media_ready_i && addr_q == fail_addr_i && idx_q == 8'h0A;
    assign media_word_o = media_valid_o ? {addr_q[7:0], idx_q} : ~{addr_q[7:0], idx_q};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= '0;
            left_q <= '0;
            idx_q <= '0;
            media_valid_o <= 1'b0;
            media_unc_o <= 1'b0;
            media_nf_o <= 1'b0;
        end else begin
            media_unc_o <= hit && !fail_nf_i;
            media_nf_o <= hit && fail_nf_i;
            if (media_rd_i) begin
                addr_q <= media_addr_i;
                left_q <= 9'h100;
                idx_q <= 8'h00;
                media_valid_o <= 1'b0;
            end else if (media_valid_o && media_ready_i) begin
                idx_q <= idx_q + 8'h01;
                // a failing sector stops its stream
                left_q <= hit ? 9'h000 : left_q - 9'h001;
                media_valid_o <= !hit && left_q > 9'h001 && idx_q[2:0] != 3'h3;
            end else if (left_q != 9'h000) begin
                media_valid_o <= 1'b1;
            end
        end
    end
endmodule : media_model

/* File: bench/multi_sector_read_command_unit_tb.sv */
/*
 * bench for the read command unit: command table, then reset.
 * assumes the media model; the bench is host.
 */
`timescale 1ns/1ps
module multi_sector_read_command_unit_tb;
    typedef struct {
        logic [7:0] op, fea, cnt; logic m; logic [27:0] ad; logic [7:0] blk; int ev;
        logic [27:0] fail; logic nf; int words, irqs; logic [7:0] err, sc; logic [27:0] radr;
    } row_t;
    localparam logic [27:0] NOF = 28'hFFF_FFFF;
    logic clk_i, rst_n_i, cmd_valid_i, media_rd_o, media_block_mode_o, media_valid_i;
    logic media_ready_o, media_unc_i, media_nf_i, data_valid_o, data_ready_i;
    logic intrq_o, done_o, fail_nf;
    logic [7:0] opcode_i, feature_i, sector_count_i, addr_low_i, addr_mid_i, addr_high_i;
    logic [7:0] device_i, block_size_i, status_o, error_o, sector_count_o;
    logic [7:0] addr_low_o, addr_mid_o, addr_high_o;
    logic [3:0] head_o;
    logic [27:0] media_addr_o, fail_addr;
    logic [15:0] media_word_i, data_o;
    logic [msr_pkg::NUM_CNT-1:0] event_i;
    int n_errors = 0;
    int tests_run = 0;
    row_t rows[11] = '{
        '{8'hC4, 0, 3, 1, 28'hA12_3456, 2, 0, NOF, 0, 768, 2, 0, 0, 28'hA12_3458},
        '{8'hC4, 0, 2, 0, 28'h300_053F, 1, 0, NOF, 0, 512, 2, 0, 0, 28'h400_0501},
        '{8'hC4, 0, 4, 1, 28'h000_0100, 4, 0, 28'h000_0102, 0, -1, 2, 8'h40, 2, 28'h000_0101},
        '{8'hC4, 0, 4, 1, 28'h000_0100, 4, 0, 28'h000_0102, 1, -1, 2, 8'h10, 2, 28'h000_0101},
        '{8'hC4, 0, 1, 1, 0, 0, 0, NOF, 0, 0, 1, 8'h04, 0, 0},
        '{8'h20, 0, 1, 1, 0, 1, 0, NOF, 0, 0, 1, 8'h04, 0, 0},
        '{8'h2F, 1, 1, 1, 28'h000_0011, 0, 3, NOF, 0, 256, 1, 0, 0, 0},
        '{8'h2F, 0, 1, 1, 28'h000_0011, 0, 0, NOF, 0, 256, 1, 0, 0, 0},
        '{8'h47, 0, 1, 1, 28'h000_0011, 0, 2, NOF, 0, 256, 1, 0, 0, 0},
        '{8'h2F, 0, 1, 1, 28'h000_0012, 0, 0, NOF, 0, 0, 1, 8'h04, 0, 0},
        '{8'hC4, 0, 0, 1, 28'h0FF_FFFF, 16, 0, NOF, 0, 65536, 16, 0, 0, 28'h100_00FE}};

    multi_sector_read_command_unit DUT (.*);
    media_model u_media (.clk_i(clk_i), .rst_n_i(rst_n_i), .media_rd_i(media_rd_o),
        .media_addr_i(media_addr_o), .media_ready_i(media_ready_o), .fail_addr_i(fail_addr),
        .fail_nf_i(fail_nf), .media_valid_o(media_valid_i), .media_word_o(media_word_i),
        .media_unc_o(media_unc_i), .media_nf_o(media_nf_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic run(input row_t r);
        int n = 0, ni = 0, t = 0;
        logic [7:0] s = 8'h00;
        logic [15:0] w0 = 16'h0000, w3 = 16'h0000;
        repeat (r.ev) begin
            @(posedge clk_i); #1 event_i = '1;
            @(posedge clk_i); #1 event_i = '0;
        end
        @(posedge clk_i); #1;
        {opcode_i, feature_i, sector_count_i, block_size_i} = {r.op, r.fea, r.cnt, r.blk};
        {addr_high_i, addr_mid_i, addr_low_i} = r.ad[23:0];
        device_i = {1'b0, r.m, 2'b00, r.ad[27:24]};
        {fail_addr, fail_nf, cmd_valid_i} = {r.fail, r.nf, 1'b1};
        @(posedge clk_i); #1 cmd_valid_i = 1'b0;
        while (t < 100000) begin
            // host stalls on short reads
            data_ready_i = !(r.words < 2000 && t % 4 == 0);
            if (data_valid_o === 1'b1 && data_ready_i) begin
                if (n == 0) w0 = data_o;
                if (n == 3) w3 = data_o;
                s += data_o[7:0] + data_o[15:8];
                n++;
            end
            ni += (intrq_o === 1'b1);
            if (done_o === 1'b1) break;
            @(posedge clk_i); #1 t++;
        end
        check(t < 100000, 1);
        if (r.words >= 0) check(n, r.words);
        check(ni, r.irqs);
        check(error_o, r.err);
        check(status_o[msr_pkg::ST_ERR], |r.err);
        if (n > 3) check(w0, r.op == 8'hC4 ? {r.ad[7:0], 8'h00} : 16'h0000);
        if (n > 3) check(w3, r.op == 8'hC4 ? {r.ad[7:0], 8'h03} : 16'(r.ev));
        if (r.op != 8'hC4 && n == 256) check(s, 8'h00);
        if (r.op == 8'hC4 && r.err != 8'h04) check(sector_count_o, r.sc);
        if (r.op == 8'hC4 && r.err != 8'h04)
            check({head_o, addr_high_o, addr_mid_o, addr_low_o}, r.radr);
    endtask : run

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (98000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end

    initial begin
        {rst_n_i, cmd_valid_i, data_ready_i, fail_nf, event_i, fail_addr} = '0;
        {opcode_i, feature_i, sector_count_i, addr_low_i, addr_mid_i, addr_high_i} = '0;
        {device_i, block_size_i} = '0;
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // reset mid-read
        @(posedge clk_i); #1 {opcode_i, block_size_i, cmd_valid_i} = {8'hC4, 8'h01, 1'b1};
        @(posedge clk_i); #1 cmd_valid_i = 1'b0;
        repeat (40) @(posedge clk_i);
        #1 rst_n_i = 1'b0;
        #1 check({status_o, media_ready_o, data_valid_o, done_o}, {8'h50, 3'b100});
        @(posedge clk_i); #1 rst_n_i = 1'b1;
        run(rows[5]);
        complete_run();
    end
endmodule : multi_sector_read_command_unit_tb
